// ==== src/mms_defines.svh ====
`ifndef MMS_DEFINES_SVH
`define MMS_DEFINES_SVH

// ************************************************************
// clock and debounce timing
// ************************************************************
`define MMS_CLK_PERIOD_NS 20
`define MMS_DEBOUNCE_US 2000
`define MMS_DEBOUNCE_CYCLES \
    ((`MMS_DEBOUNCE_US * 1000 + `MMS_CLK_PERIOD_NS - 1) / `MMS_CLK_PERIOD_NS)

// ************************************************************
// conversion timing, in internal periods and crystal cycles
// ************************************************************
`define MMS_XTAL_PER_PERIOD 2
`define MMS_CONV_PERIODS 8000
`define MMS_INT_XTAL_CYCLES 3277
`define MMS_DEINT_EXT_PERIODS 3000
`define MMS_DEINT_AUTO_PERIODS 2000

// ************************************************************
// range indices
// ************************************************************
`define MMS_RANGE_LOWEST 3'h0
`define MMS_RANGE_AC_MIN 3'h1
`define MMS_RANGE_LP_MIN 3'h1
`define MMS_RANGE_TOP 3'h4
`define MMS_RANGE_20MA 3'h0
`define MMS_RANGE_200MA 3'h1
`define MMS_SEL_ONE 5'h01
`define MMS_SEL_NONE 5'h00

`endif

// ==== src/mms_pkg.sv ====
package mms_pkg;

    // ************************************************************
    // measurement functions and conversion phases
    // ************************************************************
    typedef enum logic [2:0] {
        MMS_FN_VOLT = 3'h1,
        MMS_FN_OHM = 3'h2,
        MMS_FN_CUR = 3'h4
    } mms_func_e;

    typedef enum logic [2:0] {
        MMS_PH_INT = 3'h1,
        MMS_PH_DEINT = 3'h2,
        MMS_PH_AZ = 3'h4
    } mms_phase_e;

endpackage

// ==== src/mms_input_cond.sv ====
`timescale 1ns/1ps
`include "mms_defines.svh"

module mms_input_cond #(
    parameter int CYCLES = `MMS_DEBOUNCE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // pin, active low, pulled high
    input wire logic pin_n,
    // conditioned
    output logic level,
    output logic fall
);

    localparam int CW = $clog2(CYCLES + 1);

    logic s1_q;
    logic s2_q;
    logic stable_q;
    logic fall_q;
    logic [CW-1:0] cnt_q;

    // ************************************************************
    // synchroniser and debounce
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_q <= 1'h1;
            s2_q <= 1'h1;
        end else begin
            s1_q <= pin_n;
            s2_q <= s1_q;
        end
    end

    // a level must hold for the whole window before it counts
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= '0;
            stable_q <= 1'h1;
            fall_q <= 1'h0;
        end else begin
            fall_q <= 1'h0;
            if (s2_q == stable_q) begin
                cnt_q <= '0;
            end else if (cnt_q == CW'(CYCLES - 1)) begin
                cnt_q <= '0;
                stable_q <= s2_q;
                fall_q <= ~s2_q;
            end else begin
                cnt_q <= cnt_q + 1'h1;
            end
        end
    end

    assign level = stable_q;
    assign fall = fall_q;

endmodule // mms_input_cond

// ==== src/mms_xtal_tick.sv ====
`timescale 1ns/1ps

module mms_xtal_tick (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // crystal oscillator pin
    input wire logic xtal_in,
    // crystal edge and divided clock
    output logic xtal_rise,
    output logic internal_clock
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic rise_q;
    logic div_q;

    // ************************************************************
    // crystal edge and divide by two
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_q <= 1'h0;
            s2_q <= 1'h0;
            s3_q <= 1'h0;
            rise_q <= 1'h0;
        end else begin
            s1_q <= xtal_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            rise_q <= s2_q & ~s3_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            div_q <= 1'h0;
        end else if (rise_q) begin
            div_q <= ~div_q;
        end
    end

    assign xtal_rise = rise_q;
    assign internal_clock = div_q;

endmodule // mms_xtal_tick

// ==== src/mms_meter_sequencer.sv ====
`timescale 1ns/1ps
`include "mms_defines.svh"

// Notes on behaviour
// - current is measured in manual ranging only, never auto-ranged
// - current range is 20 mA when low_current_range_select_n is grounded, else 200 mA
// - extended resolution stays available in current function
// - low-power ohms allowed on every resistance range but 200 ohm
// - resistance auto-switches among five standard resistors 200 to 2M
// - voltage auto-switches divider taps, 200 mV to 2000 V full scale
// - power-up starts in DC coupling
// - each coupling press outside ohms toggles DC/AC; AC annunciator shows AC
// - coupling toggle in manual voltage ranging returns to auto-range
// - lowest voltage range is 2 V in AC, 200 mV in DC
// - AC coupling works on both current ranges
// - internal conversion clock is the crystal divided by two
// - a conversion lasts exactly 8000 internal periods in every mode
// - integrate lasts a fixed 1638.5 internal periods
// - deintegrate limit 3000 periods manual, 2000 auto; spare goes to zero
// - zero crossing in deintegrate ends it and enters auto-zero
// - range press while auto goes manual, keeping the last auto range
// - power-up selects auto-range
// - each further range press in manual volts or ohms steps to the next range
// - function change to volts or ohms, or option change there, ends manual ranging, back to auto
// - auto annunciator is active only while auto-range is in effect
// - select decode: 00 volt, 01 ohm, 10 current, 11 volt, pulled high
// - low-power ohms toggle in manual resistance returns to auto-range
// - low-power ohms off at power-up, toggles per press, annunciated
module mms_meter_sequencer #(
    parameter int DEBOUNCE_CYCLES = `MMS_DEBOUNCE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // front panel controls, active low
    input wire logic ohms_function_select_n,
    input wire logic current_select_n,
    input wire logic low_current_range_select_n,
    input wire logic coupling_toggle_n,
    input wire logic range_step_n,
    // converter pins
    input wire logic xtal_in,
    input wire logic zero_cross,
    // auto-range decisions from display logic
    input wire logic auto_range_up,
    input wire logic auto_range_down,
    // measurement state
    output logic func_voltage,
    output logic func_resistance,
    output logic func_current,
    output logic ac_annunciator,
    output logic auto_annunciator,
    output logic low_ohms_annunciator,
    output logic ext_resolution,
    output logic [2:0] range_index,
    output logic [4:0] divider_select,
    output logic [4:0] resistor_select,
    output logic current_range_20ma,
    // conversion sequencing
    output logic internal_clock,
    output logic phase_integrate,
    output logic phase_deintegrate,
    output logic phase_auto_zero,
    output logic conversion_done,
    output logic overrange,
    output logic [13:0] deintegrate_time
);

    // ************************************************************
    // derived counts, in crystal cycles
    // ************************************************************
    localparam logic [13:0] CONV_XTAL = 14'(`MMS_CONV_PERIODS * `MMS_XTAL_PER_PERIOD);
    localparam logic [13:0] INT_XTAL = 14'(`MMS_INT_XTAL_CYCLES);
    localparam logic [13:0] DEINT_EXT_XTAL =
        14'(`MMS_DEINT_EXT_PERIODS * `MMS_XTAL_PER_PERIOD);
    localparam logic [13:0] DEINT_AUTO_XTAL =
        14'(`MMS_DEINT_AUTO_PERIODS * `MMS_XTAL_PER_PERIOD);

    // ************************************************************
    // conditioned inputs
    // ************************************************************
    logic ohms_level;
    logic cur_level;
    logic low_cur_level;
    logic coupling_fall;
    logic range_fall;
    logic xtal_rise;
    logic zc_s1_q;
    logic zc_s2_q;

    mms_input_cond #(.CYCLES(DEBOUNCE_CYCLES)) u_ohms (
        .clk(clk),
        .reset(reset),
        .pin_n(ohms_function_select_n),
        .level(ohms_level),
        .fall()
    );

    mms_input_cond #(.CYCLES(DEBOUNCE_CYCLES)) u_cur (
        .clk(clk),
        .reset(reset),
        .pin_n(current_select_n),
        .level(cur_level),
        .fall()
    );

    mms_input_cond #(.CYCLES(DEBOUNCE_CYCLES)) u_low_cur (
        .clk(clk),
        .reset(reset),
        .pin_n(low_current_range_select_n),
        .level(low_cur_level),
        .fall()
    );

    // one press gives one event, bounces inside the window are absorbed
    mms_input_cond #(.CYCLES(DEBOUNCE_CYCLES)) u_coupling (
        .clk(clk),
        .reset(reset),
        .pin_n(coupling_toggle_n),
        .level(),
        .fall(coupling_fall)
    );

    mms_input_cond #(.CYCLES(DEBOUNCE_CYCLES)) u_range (
        .clk(clk),
        .reset(reset),
        .pin_n(range_step_n),
        .level(),
        .fall(range_fall)
    );

    mms_xtal_tick u_xtal (
        .clk(clk),
        .reset(reset),
        .xtal_in(xtal_in),
        .xtal_rise(xtal_rise),
        .internal_clock(internal_clock)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            zc_s1_q <= 1'h0;
            zc_s2_q <= 1'h0;
        end else begin
            zc_s1_q <= zero_cross;
            zc_s2_q <= zc_s1_q;
        end
    end

    // ************************************************************
    // function decode
    // ************************************************************
    mms_pkg::mms_func_e func_d;
    mms_pkg::mms_func_e func_q;
    logic func_change;

    always_comb begin
        unique case ({ohms_level, cur_level})
            2'h1: func_d = mms_pkg::MMS_FN_OHM;
            2'h2: func_d = mms_pkg::MMS_FN_CUR;
            default: func_d = mms_pkg::MMS_FN_VOLT;
        endcase
    end

    assign func_change = (func_d != func_q);

    always_ff @(posedge clk) begin
        if (reset) begin
            func_q <= mms_pkg::MMS_FN_VOLT;
        end else begin
            func_q <= func_d;
        end
    end

    // ************************************************************
    // coupling and low-power ohms options
    // ************************************************************
    logic ac_q;
    logic lp_q;
    logic is_ohm;
    logic is_cur;

    assign is_ohm = (func_q == mms_pkg::MMS_FN_OHM);
    assign is_cur = (func_q == mms_pkg::MMS_FN_CUR);

    // the same press means DC/AC toggle in volts and current, low-power in ohms
    always_ff @(posedge clk) begin
        if (reset) begin
            ac_q <= 1'h0;
        end else if (coupling_fall && !is_ohm) begin
            ac_q <= ~ac_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            lp_q <= 1'h0;
        end else if (coupling_fall && is_ohm) begin
            lp_q <= ~lp_q;
        end
    end

    // ************************************************************
    // ranging mode and range index
    // ************************************************************
    logic auto_q;
    logic auto_eff;
    logic [2:0] range_q;
    logic [2:0] min_now;
    logic [2:0] min_new_func;
    logic [2:0] min_toggled;
    logic [2:0] cur_range;

    function automatic logic [2:0] min_range(mms_pkg::mms_func_e f, logic ac, logic lp);
        logic [2:0] m;
        m = `MMS_RANGE_LOWEST;
        if (f == mms_pkg::MMS_FN_VOLT && ac) begin
            m = `MMS_RANGE_AC_MIN;
        end else if (f == mms_pkg::MMS_FN_OHM && lp) begin
            m = `MMS_RANGE_LP_MIN;
        end
        return m;
    endfunction

    assign min_now = min_range(func_q, ac_q, lp_q);
    assign min_new_func = min_range(func_d, ac_q, lp_q);
    assign min_toggled = min_range(func_q, ac_q ^ !is_ohm, lp_q ^ is_ohm);
    assign cur_range = low_cur_level ? `MMS_RANGE_200MA : `MMS_RANGE_20MA;
    assign auto_eff = auto_q && !is_cur;

    // a change of function or option always wins over a range press
    always_ff @(posedge clk) begin
        if (reset) begin
            auto_q <= 1'h1;
        end else if (func_change) begin
            auto_q <= (func_d != mms_pkg::MMS_FN_CUR);
        end else if (coupling_fall) begin
            auto_q <= !is_cur;
        end else if (range_fall && !is_cur) begin
            auto_q <= 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            range_q <= `MMS_RANGE_LOWEST;
        end else if (func_change) begin
            range_q <= min_new_func;
        end else if (is_cur) begin
            range_q <= cur_range;
        end else if (coupling_fall) begin
            range_q <= min_toggled;
        end else if (range_fall && !auto_q) begin
            // manual stepping wraps from the top back to the lowest legal range
            if (range_q >= `MMS_RANGE_TOP) begin
                range_q <= min_now;
            end else begin
                range_q <= range_q + 3'h1;
            end
        end else if (range_fall) begin
            range_q <= range_q;
        end else if (auto_q && auto_range_up && range_q < `MMS_RANGE_TOP) begin
            range_q <= range_q + 3'h1;
        end else if (auto_q && auto_range_down && range_q > min_now) begin
            range_q <= range_q - 3'h1;
        end else if (range_q < min_now) begin
            range_q <= min_now;
        end
    end

    // ************************************************************
    // registered mode outputs
    // ************************************************************
    logic [4:0] div_sel_q;
    logic [4:0] res_sel_q;
    logic ac_ann_q;
    logic auto_ann_q;
    logic lp_ann_q;
    logic ext_q;
    logic cur20_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            div_sel_q <= `MMS_SEL_NONE;
            res_sel_q <= `MMS_SEL_NONE;
        end else begin
            div_sel_q <= (func_q == mms_pkg::MMS_FN_VOLT) ?
                (`MMS_SEL_ONE << range_q) : `MMS_SEL_NONE;
            res_sel_q <= is_ohm ? (`MMS_SEL_ONE << range_q) : `MMS_SEL_NONE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ac_ann_q <= 1'h0;
            auto_ann_q <= 1'h1;
            lp_ann_q <= 1'h0;
            ext_q <= 1'h0;
            cur20_q <= 1'h0;
        end else begin
            ac_ann_q <= ac_q && !is_ohm;
            auto_ann_q <= auto_eff;
            lp_ann_q <= lp_q && is_ohm;
            ext_q <= !auto_eff;
            cur20_q <= is_cur && (range_q == `MMS_RANGE_20MA);
        end
    end

    assign func_voltage = (func_q == mms_pkg::MMS_FN_VOLT);
    assign func_resistance = is_ohm;
    assign func_current = is_cur;
    assign ac_annunciator = ac_ann_q;
    assign auto_annunciator = auto_ann_q;
    assign low_ohms_annunciator = lp_ann_q;
    assign ext_resolution = ext_q;
    assign range_index = range_q;
    assign divider_select = div_sel_q;
    assign resistor_select = res_sel_q;
    assign current_range_20ma = cur20_q;

    // ************************************************************
    // conversion sequencer
    // ************************************************************
    mms_pkg::mms_phase_e phase_q;
    logic [13:0] conv_cnt_q;
    logic [13:0] deint_max;
    logic [13:0] deint_q;
    logic conv_end;
    logic done_q;
    logic over_q;

    // the limit follows the mode live, so a mode change mid-phase takes effect at once
    assign deint_max = ext_q ? DEINT_EXT_XTAL : DEINT_AUTO_XTAL;
    assign conv_end = xtal_rise && (conv_cnt_q == CONV_XTAL - 14'h1);

    // one free counter fixes the frame length whatever the deintegrate takes
    always_ff @(posedge clk) begin
        if (reset) begin
            conv_cnt_q <= 14'h0;
        end else if (conv_end) begin
            conv_cnt_q <= 14'h0;
        end else if (xtal_rise) begin
            conv_cnt_q <= conv_cnt_q + 14'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            phase_q <= mms_pkg::MMS_PH_INT;
        end else begin
            unique case (phase_q)
                mms_pkg::MMS_PH_INT: begin
                    if (xtal_rise && conv_cnt_q == INT_XTAL - 14'h1) begin
                        phase_q <= mms_pkg::MMS_PH_DEINT;
                    end
                end
                mms_pkg::MMS_PH_DEINT: begin
                    if (zc_s2_q) begin
                        phase_q <= mms_pkg::MMS_PH_AZ;
                    end else if (xtal_rise &&
                                 conv_cnt_q == INT_XTAL + deint_max - 14'h1) begin
                        phase_q <= mms_pkg::MMS_PH_AZ;
                    end
                end
                mms_pkg::MMS_PH_AZ: begin
                    if (conv_end) begin
                        phase_q <= mms_pkg::MMS_PH_INT;
                    end
                end
                default: begin
                    phase_q <= mms_pkg::MMS_PH_AZ;
                end
            endcase
        end
    end

    // result in crystal cycles, captured at the end of deintegrate
    always_ff @(posedge clk) begin
        if (reset) begin
            deint_q <= 14'h0;
            over_q <= 1'h0;
        end else if (phase_q == mms_pkg::MMS_PH_DEINT) begin
            if (zc_s2_q) begin
                deint_q <= conv_cnt_q - INT_XTAL;
                over_q <= 1'h0;
            end else if (xtal_rise && conv_cnt_q == INT_XTAL + deint_max - 14'h1) begin
                deint_q <= deint_max;
                over_q <= 1'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            done_q <= 1'h0;
        end else begin
            done_q <= conv_end;
        end
    end

    assign phase_integrate = (phase_q == mms_pkg::MMS_PH_INT);
    assign phase_deintegrate = (phase_q == mms_pkg::MMS_PH_DEINT);
    assign phase_auto_zero = (phase_q == mms_pkg::MMS_PH_AZ);
    assign conversion_done = done_q;
    assign overrange = over_q;
    assign deintegrate_time = deint_q;

endmodule // mms_meter_sequencer

// ==== tb/mms_panel_model.sv ====
`timescale 1ns/1ps
// ****
// crystal and comparator model
// ****
module mms_panel_model #(
    parameter int ZC_CLKS = 300
) (
    // clock
    input wire logic clk,
    // bench control and block phase
    input wire logic zc_enable,
    input wire logic phase_deintegrate,
    // crystal and comparator lines
    output logic xtal_in,
    output logic zero_cross
);
    int deint_clks = 0;
    initial xtal_in = 1'h0;
    initial zero_cross = 1'h0;
    // crystal far above its real rate so a frame fits a short run; counts stay in rises
    always @(posedge clk) begin
        xtal_in <= ~xtal_in;
    end
    // comparator trips a fixed time into deintegrate, drops when the phase ends
    always @(posedge clk) begin
        deint_clks <= phase_deintegrate ? deint_clks + 1 : 0;
        zero_cross <= zc_enable && phase_deintegrate && deint_clks >= ZC_CLKS;
    end
endmodule // mms_panel_model

// ==== tb/mms_seq_chk.sv ====
`timescale 1ns/1ps
module mms_seq_chk (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // pins and state
    input wire logic xtal_in,
    input wire logic internal_clock,
    input wire logic zero_cross,
    input wire logic func_voltage,
    input wire logic func_resistance,
    input wire logic func_current,
    input wire logic auto_annunciator,
    input wire logic ext_resolution,
    input wire logic [2:0] range_index,
    input wire logic [4:0] divider_select,
    input wire logic [4:0] resistor_select,
    input wire logic phase_integrate,
    input wire logic phase_deintegrate,
    input wire logic phase_auto_zero,
    input wire logic conversion_done
);
    // ****
    // helpers, counted in crystal rises
    // ****
    logic xtal_q;
    logic live_q;
    logic run_q;
    logic seen_q;
    logic rise;
    logic [15:0] rise_q;
    logic [15:0] int_q;
    logic [15:0] deint_q;
    assign rise = xtal_in && !xtal_q;
    // helper counters start unknown, so lengths count only after one done
    always_ff @(posedge clk) begin
        xtal_q <= xtal_in;
        live_q <= !reset;
        run_q <= live_q && !reset;
        seen_q <= !reset && (seen_q || conversion_done);
        rise_q <= conversion_done ? 16'(rise) : rise_q + 16'(rise);
        int_q <= phase_integrate ? int_q + 16'(rise) : 16'h0000;
        deint_q <= phase_deintegrate ? deint_q + 16'(rise) : 16'h0000;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence s_int_end;
        $fell(phase_integrate);
    endsequence
    sequence s_deint_end;
        $fell(phase_deintegrate);
    endsequence
    a_int_to_deint: assert property (run_q ##0 s_int_end |-> phase_deintegrate)
        else $error("integrate not followed by deintegrate");
    a_deint_to_zero: assert property (run_q ##0 s_deint_end |-> phase_auto_zero)
        else $error("deintegrate not followed by auto-zero");
    a_zc_ends_deint: assert property (run_q && phase_deintegrate && zero_cross
        |-> ##[1:4] !phase_deintegrate) else $error("zero crossing ignored");
    a_frame_length: assert property (seen_q && conversion_done
        |-> rise_q == 16'h3E80) else $error("frame length wrong");
    a_int_length: assert property (seen_q ##0 s_int_end
        |-> int_q == 16'h0CCD) else $error("integrate length wrong");
    a_deint_limit: assert property (phase_deintegrate |-> deint_q <= 16'h1770)
        else $error("deintegrate too long");
    a_cur_manual: assert property (run_q && $past(func_current) && func_current
        |-> !auto_annunciator && ext_resolution) else $error("current auto-ranged");
    a_cur_range: assert property (run_q && $past(func_current) && func_current
        |-> range_index <= 3'h1) else $error("current range out of set");
    a_auto_excl: assert property (run_q && !$past(func_current) && !func_current
        |-> auto_annunciator != ext_resolution) else $error("auto annunciator wrong");
    a_divider_map: assert property (run_q && $past(func_voltage) && $stable(range_index)
        && func_voltage |-> divider_select == 5'h01 << range_index) else $error("divider wrong");
    a_resistor_map: assert property (run_q && $past(func_resistance) && $stable(range_index)
        && func_resistance |-> resistor_select == 5'h01 << range_index) else $error("resistor wrong");
    // sync, edge and divide stages put each crystal rise four clocks ahead of the toggle
    a_xtal_halve: assert property ($rose(xtal_in) |-> ##4 $changed(internal_clock))
        else $error("internal clock not halved");
endmodule // mms_seq_chk

bind mms_meter_sequencer mms_seq_chk chk_u (
    .clk, .reset, .xtal_in, .internal_clock, .zero_cross, .func_voltage, .func_resistance,
    .func_current,
    .auto_annunciator, .ext_resolution, .range_index, .divider_select, .resistor_select,
    .phase_integrate, .phase_deintegrate, .phase_auto_zero, .conversion_done
);

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic [4:0] pin_n = 5'h1F;
    logic [1:0] step = 2'h0;
    logic zc_en = 1'h0;
    logic xtal, zc, f_v, f_r, f_i, ac, au, lo, ext, i20, pi, pd, done, ovr;
    logic [2:0] rng;
    logic [4:0] dsel, rsel;
    logic [13:0] dtime;
    int fail_count = 0;
    int n_compared = 0;
    int c;
    int ci;
    always #10 clk = ~clk;
    mms_meter_sequencer #(.DEBOUNCE_CYCLES(4)) dut_u (
        .clk(clk), .reset(reset), .ohms_function_select_n(pin_n[0]),
        .current_select_n(pin_n[1]), .low_current_range_select_n(pin_n[2]),
        .coupling_toggle_n(pin_n[3]), .range_step_n(pin_n[4]), .xtal_in(xtal),
        .zero_cross(zc), .auto_range_up(step[0]), .auto_range_down(step[1]),
        .func_voltage(f_v), .func_resistance(f_r), .func_current(f_i),
        .ac_annunciator(ac), .auto_annunciator(au), .low_ohms_annunciator(lo),
        .ext_resolution(ext), .range_index(rng), .divider_select(dsel),
        .resistor_select(rsel), .current_range_20ma(i20), .internal_clock(),
        .phase_integrate(pi), .phase_deintegrate(pd), .phase_auto_zero(),
        .conversion_done(done), .overrange(ovr), .deintegrate_time(dtime)
    );
    mms_panel_model panel_u (.clk(clk), .zc_enable(zc_en), .phase_deintegrate(pd),
        .xtal_in(xtal), .zero_cross(zc));
    // ****
    // tasks
    // ****
    task automatic test_done();
        if (fail_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // press long enough for the debounce of both edges
    task automatic press(input int k);
        pin_n[k] <= 1'h0;
        repeat (12) @(posedge clk);
        pin_n[k] <= 1'h1;
        repeat (12) @(posedge clk);
    endtask
    task automatic set_pins(input logic [4:0] v);
        pin_n <= v;
        repeat (16) @(posedge clk);
    endtask
    task automatic bump(input logic [1:0] v, input int k);
        repeat (k) begin
            step <= v;
            @(posedge clk);
            step <= 2'h0;
            @(posedge clk);
        end
        repeat (3) @(posedge clk);
    endtask
    task automatic wait_frame();
        c = 0;
        ci = 0;
        do begin
            @(negedge clk);
            c++;
            ci += int'(pi === 1'h1);
        end while (done !== 1'h1 && c < 40000);
        if (c >= 40000) begin
            fail_count++;
            $display("Error conversion_done expected 1 seen 0");
            test_done();
        end
    endtask
    // ****
    // sequence
    // ****
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'h0;
        repeat (4) @(posedge clk);
        chk("func_voltage", 1'h1, f_v);
        chk("ac", 1'h0, ac);
        chk("auto", 1'h1, au);
        chk("low_ohms", 1'h0, lo);
        press(3);
        chk("ac", 1'h1, ac);
        chk("range", 3'h1, rng);
        press(3);
        chk("ac", 1'h0, ac);
        bump(2'h2, 4);
        bump(2'h1, 2);
        chk("divider", 5'h04, dsel);
        press(4);
        chk("range", 3'h2, rng);
        chk("auto", 1'h0, au);
        press(4);
        press(4);
        chk("range", 3'h4, rng);
        press(3);
        chk("auto", 1'h1, au);
        chk("range", 3'h1, rng);
        press(3);
        set_pins(5'h1E);
        chk("resistor", 5'h01, rsel);
        press(4);
        press(3);
        chk("low_ohms", 1'h1, lo);
        chk("auto", 1'h1, au);
        chk("range", 3'h1, rng);
        press(4);
        repeat (4) press(4);
        chk("range", 3'h1, rng);
        press(3);
        set_pins(5'h1D);
        chk("func_current", 1'h1, f_i);
        chk("ext_res", 1'h1, ext);
        chk("i20", 1'h0, i20);
        set_pins(5'h19);
        bump(2'h1, 1);
        press(4);
        chk("range", 3'h0, rng);
        press(3);
        chk("ac", 1'h1, ac);
        chk("i20", 1'h1, i20);
        press(3);
        set_pins(5'h1C);
        press(4);
        set_pins(5'h1E);
        chk("auto", 1'h1, au);
        set_pins(5'h1F);
        wait_frame();
        chk("overrange", 1'h1, ovr);
        chk("deint_time", 16'h0FA0, dtime);
        zc_en <= 1'h1;
        wait_frame();
        chk("frame_clks", 16'h7D00, c[15:0]);
        chk("int_clks", 16'h199A, ci[15:0]);
        chk("overrange", 1'h0, ovr);
        n_compared++;
        if ($isunknown(dtime) || dtime < 14'h0096 || dtime > 14'h009C) begin
            fail_count++;
            $display("Error deint_time expected 0096..009C seen %h", dtime);
        end
        test_done();
    end
endmodule // tb_top
